// ===== dv/dfsi_front_model.sv
// Rotary switch and loopback plug model at the drive front
`timescale 1ns/10ps
module dfsi_front_model #(
    parameter logic [3:0] HI = 4'h8,
    parameter logic [3:0] LO = 4'h2 // Even, extra encoder on high digit bit 3 set
) (
    // Switches
    output logic [3:0] hi_digit,
    output logic [3:0] lo_digit,
    // Plug
    output logic       loop_rx_tx,
    output logic       loop_dsr_dtr
);
    logic plugged = 1'b1;
    assign hi_digit = HI;
    assign lo_digit = LO;
    // Plug bridges both pairs at startup
    assign loop_rx_tx = plugged;
    assign loop_dsr_dtr = plugged;
    // Pulled after boot, so only the startup sample may count
    initial #3000 plugged = 1'b0;
endmodule

// ===== dv/tb_drive_fault_status_indicator.sv
// Self-checking bench for the fault status block
`timescale 1ns/10ps
module tb_drive_fault_status_indicator;
    import dfsi_pkg::*;
    logic        clock, rst_n, cyc, stb, we, ack, rel, bpwm, dcf, fb2, boot, bal, mod;
    logic [7:0]  adr, node;
    logic [3:0]  sel, hi, lo;
    logic [31:0] wd, rd;
    logic        lrx, ldsr;
    logic [50:0] fi;
    logic [11:0] wi;
    logic [23:0] qual;
    logic [2:0]  fe, cpb, mpb, act, red, eled, cled, mled;
    logic [47:0] icmd, ilim;
    int          fails, num_checks;
    ////////////////////////////////////////////////////////////////////
    dfsi_front_model front (.hi_digit(hi), .lo_digit(lo), .loop_rx_tx(lrx),
        .loop_dsr_dtr(ldsr));
    dfsi_top uut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
        .wb_ack_o(ack), .release_input_zero(rel), .high_address_digit(hi),
        .low_address_digit(lo), .serial_loop_rx_tx(lrx), .serial_loop_dsr_dtr(ldsr),
        .axis_fault_in(fi), .axis_warn_in(wi), .encoder_amplitude_quality(qual),
        .following_error_over(fe), .ctrl_params_bad(cpb), .motor_params_bad(mpb),
        .current_command(icmd), .ballast_pwm(bpwm), .dc_link_falling(dcf),
        .axis_active(act), .reduced_mode_out(red), .current_limited(ilim),
        .error_led(eled), .control_led(cled), .motor_led(mled), .ballast_led(bal),
        .modulation_led(mod), .node_address(node), .second_feedback(fb2),
        .fallback_boot(boot));
    ////////////////////////////////////////////////////////////////////
    always #50 clock = ~clock;
    task automatic conclude;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Holds the request until ack is sampled high at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hF};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20)
            fails++;
        q = rd;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic clr(input logic [7:0] c);
        logic [31:0] q;
        bus(1'b1, c, 32'h0, q);
        bus(1'b1, c, 32'h2, q);
        bus(1'b1, c, 32'h1, q);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_faults;
        logic [31:0] q;
        bus(1'b1, REG_CTRL, 32'h1, q);
        bus(1'b0, REG_CTRL, 32'h0, q);
        chk(q, 32'h1);
        for (int k = 0; k < FLT_BITS; k++) begin
            @(posedge clock);
            fi[k] <= 1'b1;
            settle(3);
            chk(act[0], 1'b0);
            chk(eled[0], 1'b1);
            @(posedge clock);
            fi[k] <= 1'b0;
            bus(1'b0, REG_FAULT, 32'h0, q);
            chk(q, 32'h1 << k);
            clr(REG_CTRL);
            settle(3);
            chk(act[0], 1'b1);
        end
    endtask
    task automatic t_misc;
        logic [31:0] q;
        bus(1'b0, 8'hFC, 32'h0, q);
        chk(q, 32'h0);
        chk({fb2, boot, node}, {2'b11, 8'h82});
        @(posedge clock);
        rel <= 1'b0;
        settle(3);
        chk(act, 3'b000);
        @(posedge clock);
        {rel, qual[7:0]} <= {1'b1, 8'h27};
        settle(3);
        bus(1'b0, REG_FAULT, 32'h0, q);
        chk(q, (32'h1 << FLT_ENC) | (32'h1 << FLT_RELEASE));
        @(posedge clock);
        {qual[7:0], icmd[47:32]} <= {8'h3C, 16'h2000};
        clr(REG_CTRL);
        bus(1'b1, REG_CTRL + 8'h20, 32'h4, q);
        settle(2);
        chk({red[2], ilim[47:32]}, {1'b1, REDUCED_CURRENT_LIMIT_RESET});
    endtask
    task automatic t_recommute;
        logic [31:0] q;
        bus(1'b1, REG_CTRL + 8'h20, 32'h8, q);
        @(posedge clock);
        qual[23:16] <= 8'h10;
        settle(2);
        @(posedge clock);
        qual[23:16] <= 8'h3C;
        bus(1'b1, REG_CTRL + 8'h20, 32'hA, q);
        bus(1'b1, REG_CTRL + 8'h20, 32'h9, q);
        bus(1'b0, REG_FAULT + 8'h20, 32'h0, q);
        chk(q, 32'h1 << FLT_COMM);
        chk(act[2], 1'b0);
    endtask
    task automatic t_ind;
        logic [31:0] q;
        @(posedge clock);
        {cpb[1], mpb[2], bpwm, dcf, fe[1]} <= 5'h1F;
        settle(1);
        chk({cled, mled}, 6'h14);
        chk({bal, eled[1], mod}, 3'h6);
        @(posedge clock);
        {dcf, fi[25], wi[7:4]} <= 6'h19;
        settle(2);
        chk({bal, mod}, 2'h1);
        bus(1'b0, REG_GLOBAL, 32'h0, q);
        chk(q, 32'h03821000);
        bus(1'b0, AXIS_STRIDE, 32'h0, q);
        chk(q, 32'h00001101);
        bus(1'b0, AXIS_STRIDE + REG_WARN, 32'h0, q);
        chk(q, 32'h00000090);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {clock, rst_n, cyc, stb, we, adr, sel, wd, bpwm, dcf} = '0;
        {fi, wi, fe, cpb, mpb, icmd, rel, qual} = {120'h0, 1'b1, {3{8'h3C}}};
        {fails, num_checks} = '0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_faults;
        t_misc;
        t_recommute;
        t_ind;
        conclude;
    end
    initial begin
        #2000000;
        fails++;
        conclude;
    end
endmodule

// ===== hdl/dfsi_axis.sv
// One axis: sticky fault word, warnings and active state machine
`timescale 1ns/10ps
module dfsi_axis
    import dfsi_pkg::*;
(
    // Clock and reset
    input wire logic  clock,
    input wire logic  rst_n,
    // Axis link
    dfsi_axis_if.keeper ax
);
    import dfsi_pkg::*;

    dfsi_axis_t  state;
    dfsi_axis_t  next_state;
    logic [31:0] fault_word;
    logic [31:0] next_fault_word;
    logic        was_enc;
    logic        next_was_enc;

    always_comb begin
        next_state      = state;
        next_was_enc    = was_enc;
        // Set beats clear: a fresh event in the ack cycle stays
        next_fault_word = ax.ack_pulse ? 32'h00000000 : fault_word;
        next_fault_word = (next_fault_word | ax.raw_fault) & FLT_USED;
        if (ax.raw_fault[FLT_ENC]) begin
            next_was_enc = 1'b1;
        end else if (ax.raw_fault[FLT_COMM]) begin
            // Offset failure forces recommutation, so the lost position is settled
            next_was_enc = 1'b0;
        end
        unique case (state)
            DFSI_IDLE: begin
                if (ax.cmd_active && ax.release_ok && next_fault_word == 32'h00000000) begin
                    next_state = DFSI_RUN;
                end
            end
            DFSI_RUN: begin
                if (next_fault_word != 32'h00000000 || !ax.release_ok) begin
                    next_state = DFSI_HALT;
                end else if (!ax.cmd_active) begin
                    next_state = DFSI_IDLE;
                end
            end
            DFSI_HALT: begin
                // Recovery needs inactive, then ack, then active
                if (!ax.cmd_active && ax.ack_pulse) begin
                    next_state = DFSI_ACKED;
                end
            end
            DFSI_ACKED: begin
                if (next_fault_word != 32'h00000000) begin
                    next_state = DFSI_HALT;
                end else if (ax.cmd_active) begin
                    next_state = DFSI_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state      <= DFSI_IDLE;
            fault_word <= 32'h00000000;
            was_enc    <= 1'b0;
        end else begin
            state      <= next_state;
            fault_word <= next_fault_word;
            was_enc    <= next_was_enc;
        end
    end

    assign ax.fault_word = fault_word;
    assign ax.warn_word  = ax.raw_warn & WRN_USED;
    assign ax.active     = (state == DFSI_RUN) && ax.release_ok;
    assign ax.was_enc    = was_enc;

    a_fault_drops_active: assert property (@(posedge clock) disable iff (!rst_n)
        (|ax.raw_fault) |=> !ax.active)
        else $error("axis stayed active after a fault");
    a_fault_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        (ax.raw_fault[FLT_SPEED] ##1 !ax.ack_pulse) |-> fault_word[FLT_SPEED])
        else $error("fault bit lost without acknowledge");
    a_release_gates: assert property (@(posedge clock) disable iff (!rst_n)
        !ax.release_ok |-> !ax.active ##1 (state != DFSI_RUN))
        else $error("active without release");
    a_unused_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (fault_word & ~FLT_USED) == 32'h00000000)
        else $error("unused fault bit set");
    // Release may drop in the next cycle, so watch the state, not the output
    a_warn_only: assert property (@(posedge clock) disable iff (!rst_n)
        (state == DFSI_RUN && ax.raw_fault == 32'h00000000 && ax.release_ok
         && ax.cmd_active && !(|fault_word)) |=> (state == DFSI_RUN))
        else $error("warning alone stopped the axis");
endmodule

// ===== hdl/dfsi_axis_if.sv
// Interface between the top and one axis fault keeper
`timescale 1ns/10ps
interface dfsi_axis_if;
    logic [31:0] fault_word;
    logic [31:0] warn_word;
    logic [31:0] raw_fault;
    logic [31:0] raw_warn;
    logic        cmd_active;
    logic        ack_pulse;
    logic        release_ok;
    logic        active;
    logic        was_enc;
    modport keeper (output fault_word, warn_word, active, was_enc,
                    input raw_fault, raw_warn, cmd_active, ack_pulse, release_ok);
    modport top (input fault_word, warn_word, active, was_enc,
                 output raw_fault, raw_warn, cmd_active, ack_pulse, release_ok);
endinterface

// ===== hdl/dfsi_pkg.sv
// Package of constants and types for the drive fault status indicator
package dfsi_pkg;
    localparam int          NUM_AXES     = 3;
    localparam int          FLT_STOP     = 0;
    localparam int          FLT_UNDERV   = 1;
    localparam int          FLT_OVERV    = 2;
    localparam int          FLT_I2T      = 3;
    localparam int          FLT_STAGE    = 4;
    localparam int          FLT_MOTOR    = 5;
    localparam int          FLT_SHORT    = 6;
    localparam int          FLT_ENC      = 7;
    localparam int          FLT_SPEED    = 8;
    localparam int          FLT_RELAY    = 9;
    localparam int          FLT_COMM     = 10;
    localparam int          FLT_ENDSTOP  = 11;
    localparam int          FLT_PHASE    = 12;
    localparam int          FLT_IRQ      = 13;
    localparam int          FLT_RELEASE  = 14;
    localparam int          FLT_CONFIG   = 15;
    localparam int          FLT_FIELDBUS = 16;
    localparam int          FLT_BITS     = 17;
    localparam logic [31:0] FLT_USED     = 32'h0001FFFF;
    localparam int          WRN_STAGE    = 4;
    localparam int          WRN_I2T      = 5;
    localparam int          WRN_MOTOR    = 6;
    localparam int          WRN_MOD      = 7;
    localparam logic [31:0] WRN_USED     = 32'h000000F0;
    localparam logic [7:0]  RES_Q_MIN    = 8'h28;
    localparam logic [7:0]  SC_Q_MIN     = 8'h14;
    localparam logic [7:0]  Q_MAX        = 8'h50;
    localparam logic [7:0]  ADDR_FB2     = 8'h80;
    // Register byte offsets; one block of four words per axis
    localparam logic [7:0]  REG_FAULT    = 8'h00;
    localparam logic [7:0]  REG_WARN     = 8'h04;
    localparam logic [7:0]  REG_CTRL     = 8'h08;
    localparam logic [7:0]  REG_STAT     = 8'h0C;
    localparam logic [7:0]  REG_GLOBAL   = 8'h30;
    localparam logic [7:0]  AXIS_STRIDE  = 8'h10;
    localparam int          CTRL_ACTIVE  = 0;
    localparam int          CTRL_ACK     = 1;
    localparam int          CTRL_REDUCE  = 2;
    localparam int          CTRL_AUTOCOM = 3;
    localparam int          CTRL_SINCOS  = 4;
    localparam int          SLOW_DIV     = 22;
    localparam int          FAST_DIV     = 20;
    localparam logic [15:0] REDUCED_CURRENT_LIMIT_RESET   = 16'h1000;
    typedef enum logic [1:0] {DFSI_OFF, DFSI_ON, DFSI_SLOW, DFSI_FAST} dfsi_led_t;
    typedef enum {DFSI_IDLE, DFSI_RUN, DFSI_HALT, DFSI_ACKED} dfsi_axis_t;
endpackage

// ===== hdl/dfsi_top.sv
// Drive fault status indicator top with Wishbone register slave
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/10ps
module dfsi_top
    import dfsi_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // Wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output      logic [31:0]             wb_dat_o,
    output      logic                    wb_ack_o,
    // Release and switches
    input  wire logic                    release_input_zero,
    input  wire logic [3:0]              high_address_digit,
    input  wire logic [3:0]              low_address_digit,
    input  wire logic                    serial_loop_rx_tx,
    input  wire logic                    serial_loop_dsr_dtr,
    // Per axis condition inputs
    input  wire logic [NUM_AXES*17-1:0]  axis_fault_in,
    input  wire logic [NUM_AXES*4-1:0]   axis_warn_in,
    input  wire logic [NUM_AXES*8-1:0]   encoder_amplitude_quality,
    input  wire logic [NUM_AXES-1:0]     following_error_over,
    input  wire logic [NUM_AXES-1:0]     ctrl_params_bad,
    input  wire logic [NUM_AXES-1:0]     motor_params_bad,
    input  wire logic [NUM_AXES*16-1:0]  current_command,
    // Ballast monitor
    input  wire logic                    ballast_pwm,
    input  wire logic                    dc_link_falling,
    // Outputs
    output      logic [NUM_AXES-1:0]     axis_active,
    output      logic [NUM_AXES-1:0]     reduced_mode_out,
    output      logic [NUM_AXES*16-1:0]  current_limited,
    output      logic [NUM_AXES-1:0]     error_led,
    output      logic [NUM_AXES-1:0]     control_led,
    output      logic [NUM_AXES-1:0]     motor_led,
    output      logic                    ballast_led,
    output      logic                    modulation_led,
    output      logic [7:0]              node_address,
    output      logic                    second_feedback,
    output      logic                    fallback_boot
);
    import dfsi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic quality_ok(input logic [7:0] q, input logic sincos);
        logic [7:0] lo;
        lo = sincos ? SC_Q_MIN : RES_Q_MIN;
        return (q >= lo) && (q <= Q_MAX);
    endfunction

    function automatic logic led_drive(input dfsi_led_t m, input logic slow, input logic fast);
        logic v;
        v = 1'b0;
        unique case (m)
            DFSI_OFF:  v = 1'b0;
            DFSI_ON:   v = 1'b1;
            DFSI_SLOW: v = slow;
            DFSI_FAST: v = fast;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Blink timebase
    logic [SLOW_DIV-1:0] blink;
    logic [SLOW_DIV-1:0] next_blink;
    logic                slow_ph;
    logic                fast_ph;

    always_comb begin
        next_blink = blink + {{(SLOW_DIV-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            blink <= '0;
        end else begin
            blink <= next_blink;
        end
    end

    assign slow_ph = blink[SLOW_DIV-1];
    assign fast_ph = blink[FAST_DIV-1];

    ////////////////////////////////////////////////////////////////////////////
    // Registers and bus slave
    logic [4:0]  ctrl     [NUM_AXES];
    logic [4:0]  next_ctrl[NUM_AXES];
    logic [15:0] reduced_current_limit;
    logic [15:0] next_reduced_current_limit;
    logic        ack;
    logic        next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic        wr_take;
    logic        ballast_err;
    logic        next_ballast_err;
    logic        boot_seen;
    logic        next_boot_seen;
    logic        boot_mode;
    logic        next_boot_mode;
    logic [NUM_AXES-1:0] ack_pulse;
    logic [NUM_AXES-1:0] offset_fail;
    logic [NUM_AXES-1:0] next_offset_fail;
    logic [NUM_AXES-1:0] prev_cmd;

    dfsi_axis_if ax_if[NUM_AXES] ();
    logic [31:0] ax_if_fault[NUM_AXES];
    logic [31:0] ax_if_warn [NUM_AXES];

    assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !ack;

    always_comb begin
        next_ack   = wb_cyc_i && wb_stb_i && !ack;
        next_rdata = 32'h00000000;
        next_reduced_current_limit  = reduced_current_limit;
        for (int i = 0; i < NUM_AXES; i++) begin
            next_ctrl[i] = ctrl[i];
            next_ctrl[i][CTRL_ACK] = 1'b0;
        end
        if (wr_take && wb_sel_i[0]) begin
            for (int i = 0; i < NUM_AXES; i++) begin
                if (wb_adr_i == REG_CTRL + AXIS_STRIDE * 8'(i)) begin
                    next_ctrl[i] = wb_dat_i[4:0];
                end
            end
        end
        if (wr_take && wb_adr_i == REG_GLOBAL) begin
            if (wb_sel_i[0]) begin
                next_reduced_current_limit[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                next_reduced_current_limit[15:8] = wb_dat_i[15:8];
            end
        end
        for (int i = 0; i < NUM_AXES; i++) begin
            unique case (wb_adr_i - AXIS_STRIDE * 8'(i))
                REG_FAULT: next_rdata = ax_if_fault[i];
                REG_WARN:  next_rdata = ax_if_warn[i];
                REG_CTRL:  next_rdata = {27'h0, ctrl[i]};
                REG_STAT:  next_rdata = {30'h0, offset_fail[i], axis_active[i]};
                default:   ;
            endcase
        end
        if (wb_adr_i == REG_GLOBAL) begin
            next_rdata = {6'h0, boot_mode, ballast_err, node_address, reduced_current_limit};
        end
        if (!(wb_cyc_i && wb_stb_i && !wb_we_i)) begin
            next_rdata = rdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack   <= 1'b0;
            rdata <= 32'h00000000;
            reduced_current_limit  <= REDUCED_CURRENT_LIMIT_RESET;
            for (int i = 0; i < NUM_AXES; i++) begin
                ctrl[i] <= 5'h00;
            end
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
            reduced_current_limit  <= next_reduced_current_limit;
            for (int i = 0; i < NUM_AXES; i++) begin
                ctrl[i] <= next_ctrl[i];
            end
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Axis keepers

    for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
        logic [31:0] raw;
        always_comb begin
            raw = {15'h0, axis_fault_in[g*17 +: 17]};
            raw[FLT_RELEASE] = raw[FLT_RELEASE] ||
                (!release_input_zero && ctrl[g][CTRL_ACTIVE]);
            raw[FLT_ENC]  = raw[FLT_ENC] ||
                !quality_ok(encoder_amplitude_quality[g*8 +: 8], ctrl[g][CTRL_SINCOS]);
            raw[FLT_PHASE] = raw[FLT_PHASE] || ballast_err;
            raw[FLT_COMM] = raw[FLT_COMM] || next_offset_fail[g];
            raw[FLT_STOP] = raw[FLT_STOP] || following_error_over[g];
        end
        assign ax_if[g].raw_fault  = raw;
        assign ax_if[g].raw_warn   = {24'h0, axis_warn_in[g*4 +: 4], 4'h0};
        assign ax_if[g].cmd_active = ctrl[g][CTRL_ACTIVE];
        assign ax_if[g].ack_pulse  = ctrl[g][CTRL_ACK];
        assign ax_if[g].release_ok = release_input_zero;
        assign ax_if_fault[g]      = ax_if[g].fault_word;
        assign ax_if_warn[g]       = ax_if[g].warn_word;
        assign axis_active[g]      = ax_if[g].active;
        assign reduced_mode_out[g] = ctrl[g][CTRL_REDUCE];
        assign current_limited[g*16 +: 16] =
            (ctrl[g][CTRL_REDUCE] && current_command[g*16 +: 16] > reduced_current_limit) ?
            reduced_current_limit : current_command[g*16 +: 16];
        assign next_offset_fail[g] = ctrl[g][CTRL_AUTOCOM] && ax_if[g].was_enc &&
            ctrl[g][CTRL_ACTIVE] && !prev_cmd[g];
        assign error_led[g] = led_drive(
            |ax_if[g].fault_word ? DFSI_ON : (|ax_if[g].warn_word ? DFSI_SLOW :
            ((ctrl_params_bad[g] || motor_params_bad[g]) && !axis_active[g]
             ? DFSI_FAST : DFSI_OFF)), slow_ph, fast_ph);
        assign control_led[g] = ctrl_params_bad[g] && !axis_active[g];
        assign motor_led[g]   = motor_params_bad[g] && !axis_active[g];
        dfsi_axis u_axis (
            .clock (clock),
            .rst_n (rst_n),
            .ax    (ax_if[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ballast, address and fallback boot
    logic [NUM_AXES-1:0] any_speed;
    logic [NUM_AXES-1:0] any_mod;
    for (genvar g = 0; g < NUM_AXES; g++) begin : g_mod
        assign any_speed[g] = ax_if_fault[g][FLT_SPEED] | ax_if_fault[g][FLT_SHORT];
        assign any_mod[g]   = ax_if_warn[g][WRN_MOD];
    end

    always_comb begin
        next_ballast_err = ballast_err;
        if (ballast_pwm && !dc_link_falling) begin
            next_ballast_err = 1'b1;
        end else if (|ack_pulse) begin
            next_ballast_err = 1'b0;
        end
        // Strap sampled once after reset release, not under reset
        next_boot_seen = 1'b1;
        next_boot_mode = boot_seen ? boot_mode :
            (serial_loop_rx_tx && serial_loop_dsr_dtr);
        for (int i = 0; i < NUM_AXES; i++) begin
            ack_pulse[i] = ctrl[i][CTRL_ACK];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ballast_err <= 1'b0;
            boot_seen   <= 1'b0;
            boot_mode   <= 1'b0;
            offset_fail <= '0;
            prev_cmd    <= '0;
            node_address    <= 8'h00;
            second_feedback <= 1'b0;
        end else begin
            ballast_err <= next_ballast_err;
            boot_seen   <= next_boot_seen;
            boot_mode   <= next_boot_mode;
            offset_fail <= next_offset_fail;
            for (int i = 0; i < NUM_AXES; i++) begin
                prev_cmd[i] <= ctrl[i][CTRL_ACTIVE];
            end
            node_address    <= {high_address_digit, low_address_digit};
            second_feedback <= high_address_digit[3];
        end
    end

    assign ballast_led    = ballast_err ? 1'b0 : ballast_pwm;
    assign modulation_led = led_drive(|any_speed ? DFSI_ON :
        (|any_mod ? DFSI_SLOW : DFSI_OFF), slow_ph, fast_ph);
    assign fallback_boot  = boot_mode;

    a_ballast_fault: assert property (@(posedge clock) disable iff (!rst_n)
        (ballast_pwm && !dc_link_falling) |=> ballast_err)
        else $error("ballast fault not raised");
    a_clamp_current: assert property (@(posedge clock) disable iff (!rst_n)
        reduced_mode_out[NUM_AXES-1] |->
        current_limited[(NUM_AXES-1)*16 +: 16] <= reduced_current_limit)
        else $error("current not clamped");
    a_boot_holds: assert property (@(posedge clock) disable iff (!rst_n)
        boot_seen |=> $stable(boot_mode))
        else $error("boot mode changed after startup");
    // Not on the edge that leaves reset: the register is still cleared there
    a_fb2_bit: assert property (@(posedge clock) disable iff (!rst_n)
        (rst_n && high_address_digit[3]) |=> second_feedback)
        else $error("second feedback not enabled");
endmodule
